// *** rtl/apcs_pkg.sv ***
package apcs_pkg;
	localparam int WORD_W = 8;
	localparam int MAG_W = 22;
	localparam int STEP_W = 4;
	localparam int ACC_W = MAG_W + STEP_W;
	localparam int SEG_N = 8;
	localparam int SAMPLE_W = MAG_W + 1;
	localparam int FIFO_DEPTH = 16;
	localparam int SIGN_POS = 7;
	localparam int CHORD_HI = 6;
	localparam int CHORD_LO = 4;
	localparam int STEP_HI = 3;
	localparam logic [3:0] BITS_PER_WORD = 4'h8;
	localparam logic [1:0] SAR_TOP = 2'h3;
	localparam logic SIGN_POSITIVE = 1'b1;
	localparam logic [7:0] IDLE_WORD = 8'hd0;
	localparam int MCLK_PERIOD_NS = 25;
	localparam int FRAME_PERIOD_NS = 125000;
	localparam int FRAME_CYCLES = FRAME_PERIOD_NS / MCLK_PERIOD_NS;
	localparam int BIT_PERIOD_NS = 500;
	localparam int BCLK_HALF_CYCLES = BIT_PERIOD_NS / (2 * MCLK_PERIOD_NS);
	localparam int RX_GAP_MIN_CYCLES = 17;
	localparam int TX_GAP_MIN_CYCLES = 1;
	localparam logic [2:0] CHORD_CODE [SEG_N] = '{3'h5, 3'h4, 3'h7, 3'h6,
		3'h1, 3'h0, 3'h3, 3'h2};
	// Levels in microvolts.
	localparam logic [MAG_W-1:0] SEG_BASE [SEG_N] = '{22'h0, 22'h4e84,
		22'h9d6c, 22'h13ad8, 22'h2754c, 22'h510e0, 22'h9d788, 22'h13ab28};
	localparam logic [MAG_W-1:0] SEG_STEP [SEG_N] = '{22'h4c5, 22'h4c5,
		22'h988, 22'h1310, 22'h262a, 22'h4c4a, 22'h98bc, 22'h13114};
endpackage: apcs_pkg

// *** rtl/apcs_link_if.sv ***
`timescale 1ns/100ps
interface apcs_link_if;
	logic transmit_frame_strobe;
	logic transmit_bit_clock;
	logic receive_frame_strobe;
	logic receive_bit_clock;
	logic tx_serial_out;
	logic tx_serial_oe;
	logic tx_serial_line;
	logic rx_serial_data;
	// The released output line floats up to one, as the pull-up does.
	assign tx_serial_line = tx_serial_oe ? tx_serial_out : 1'b1;
	modport dev (
		input transmit_frame_strobe,
		input transmit_bit_clock,
		input receive_frame_strobe,
		input receive_bit_clock,
		input rx_serial_data,
		output tx_serial_out,
		output tx_serial_oe
	);
	modport mux (
		output transmit_frame_strobe,
		output transmit_bit_clock,
		output receive_frame_strobe,
		output receive_bit_clock,
		output rx_serial_data,
		input tx_serial_line
	);
endinterface: apcs_link_if

// *** rtl/apcs_fifo.sv ***
`timescale 1ns/100ps
module apcs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	always_comb begin
		next_count = count;
		if (push && !pop)
			next_count = count + 1'b1;
		else if (pop && !push)
			next_count = count - 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			count <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			count <= next_count;
			in_ready <= next_count != (AW+1)'(DEPTH);
			out_valid <= next_count != '0;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule: apcs_fifo

// *** rtl/apcs_codec_dev.sv ***
// Summary of operation
// RULE1: Partner never holds a frame strobe high.
// RULE2: Transmit strobe low one mclk between words.
// RULE3: Receive strobe low seventeen mclk between words.
// RULE4: Offset cycle precedes every conversion.
// RULE5: Offset nulling leaves the sign bit alone.
// RULE6: Chord codes map segments 101,100,...,010.
// RULE7: Magnitude is base plus steps times size.
// RULE8: Frame strobes last eight bit clock periods.
// RULE9: Frame strobes repeat every 125 microseconds.
// RULE10: First bit taken when strobe, clock high.
// RULE11: Drive bits on rising edges, release after.
// RULE12: Receive strobe falls before ninth rising edge.
// RULE13: Sign, chord, step; most significant first.
`timescale 1ns/100ps
module apcs_codec_dev (
	input wire logic mclk,
	input wire logic srst,
	apcs_link_if.dev link,
	input wire logic sample_valid,
	output logic sample_ready,
	input wire logic sample_sign,
	input wire logic [apcs_pkg::MAG_W-1:0] sample_mag,
	input wire logic [apcs_pkg::MAG_W-1:0] offset_level,
	output logic dec_valid,
	output logic dec_sign,
	output logic [apcs_pkg::MAG_W-1:0] dec_mag
);
	typedef enum logic [2:0] {
		ENC_IDLE, ENC_OFFSET, ENC_SEGMENT, ENC_STEP, ENC_DONE
	} apcs_enc_state_t;

	apcs_enc_state_t state;
	logic [2:0] strb_sync [2];
	logic [1:0] strb_lvl;
	logic [1:0] strb_prev;
	logic tx_rise;
	logic tx_fall;
	logic rx_fall;
	logic fifo_valid;
	logic fifo_pop;
	logic [apcs_pkg::SAMPLE_W-1:0] fifo_data;
	logic raw_sign;
	logic [apcs_pkg::MAG_W-1:0] raw_mag;
	logic [apcs_pkg::MAG_W-1:0] conv_mag;
	logic [2:0] seg;
	logic [2:0] seg_sel;
	logic [apcs_pkg::SEG_N-1:0] seg_ge;
	logic [3:0] acc;
	logic [3:0] trial;
	logic [1:0] sar_bit;
	logic [apcs_pkg::ACC_W-1:0] trial_level;
	logic [apcs_pkg::WORD_W-1:0] result;
	logic [apcs_pkg::WORD_W-1:0] tx_word;
	logic tx_rst_meta;
	logic tx_rst;
	logic [3:0] tx_cnt;
	logic [apcs_pkg::WORD_W-1:0] tx_sh;
	logic rx_rst_meta;
	logic rx_rst;
	logic [3:0] rx_cnt;
	logic [apcs_pkg::WORD_W-1:0] rx_sh;
	logic [apcs_pkg::SEG_N-1:0] dec_match;
	logic [2:0] dec_seg;

	// Samples wait here so a slow frame rate back-pressures the source.
	apcs_fifo #(
		.WIDTH(apcs_pkg::SAMPLE_W),
		.DEPTH(apcs_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.srst(srst),
		.in_valid(sample_valid),
		.in_ready(sample_ready),
		.in_data({sample_sign, sample_mag}),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	// Strobes come from the bit clock domains; three stages, two agree.
	generate
		for (genvar s = 0; s < 2; s++) begin : g_strb
			logic pin;
			assign pin = (s == 0) ? link.transmit_frame_strobe :
				link.receive_frame_strobe;
			always_ff @(posedge mclk) begin
				if (srst) begin
					strb_sync[s] <= 3'h0;
					strb_lvl[s] <= 1'b0;
					strb_prev[s] <= 1'b0;
				end else begin
					strb_sync[s] <= {strb_sync[s][1:0], pin};
					if (strb_sync[s][1] == strb_sync[s][2])
						strb_lvl[s] <= strb_sync[s][2];
					strb_prev[s] <= strb_lvl[s];
				end
			end
		end
	endgenerate

	assign tx_rise = strb_lvl[0] && !strb_prev[0];
	assign tx_fall = !strb_lvl[0] && strb_prev[0];
	assign rx_fall = !strb_lvl[1] && strb_prev[1];
	assign fifo_pop = (state == ENC_IDLE) && tx_rise;

	always_ff @(posedge mclk) begin
		if (srst) begin
			state <= ENC_IDLE;
		end else begin
			unique case (state)
				ENC_IDLE: if (tx_rise) state <= ENC_OFFSET;
				ENC_OFFSET: state <= ENC_SEGMENT; // see RULE4
				ENC_SEGMENT: state <= ENC_STEP;
				ENC_STEP: if (sar_bit == 2'h0) state <= ENC_DONE;
				ENC_DONE: state <= ENC_IDLE;
			endcase
		end
	end

	// An empty queue converts a positive zero rather than stalling.
	always_ff @(posedge mclk) begin
		if (srst) begin
			raw_sign <= apcs_pkg::SIGN_POSITIVE;
			raw_mag <= '0;
		end else if (fifo_pop) begin
			raw_sign <= fifo_valid ? fifo_data[apcs_pkg::MAG_W] :
				apcs_pkg::SIGN_POSITIVE;
			raw_mag <= fifo_valid ? fifo_data[apcs_pkg::MAG_W-1:0] : '0;
		end
	end

	// Only the magnitude is nulled, so a zero input keeps its sign.
	always_ff @(posedge mclk) begin
		if (srst)
			conv_mag <= '0;
		else if (state == ENC_OFFSET)
			conv_mag <= (raw_mag > offset_level) ?
				raw_mag - offset_level : '0; // see RULE4 see RULE5
	end

	generate
		for (genvar i = 0; i < apcs_pkg::SEG_N; i++) begin : g_seg
			assign seg_ge[i] = conv_mag >= apcs_pkg::SEG_BASE[i];
			assign dec_match[i] = rx_sh[apcs_pkg::CHORD_HI:apcs_pkg::CHORD_LO]
				== apcs_pkg::CHORD_CODE[i];
		end
	endgenerate

	always_comb begin
		seg_sel = 3'h0;
		dec_seg = 3'h0;
		for (int i = 0; i < apcs_pkg::SEG_N; i++) begin
			if (seg_ge[i])
				seg_sel = 3'(i);
			if (dec_match[i])
				dec_seg = 3'(i);
		end
	end

	always_comb begin
		trial = acc;
		trial[sar_bit] = 1'b1;
		trial_level = apcs_pkg::ACC_W'(trial) *
			apcs_pkg::ACC_W'(apcs_pkg::SEG_STEP[seg]) +
			apcs_pkg::ACC_W'(apcs_pkg::SEG_BASE[seg]);
	end

	// Steps are found by successive approximation, one bit per cycle.
	always_ff @(posedge mclk) begin
		if (srst) begin
			seg <= 3'h0;
			acc <= 4'h0;
			sar_bit <= apcs_pkg::SAR_TOP;
			result <= apcs_pkg::IDLE_WORD;
		end else begin
			unique case (state)
				ENC_SEGMENT: begin
					seg <= seg_sel;
					acc <= 4'h0;
					sar_bit <= apcs_pkg::SAR_TOP;
				end
				ENC_STEP: begin
					if (trial_level <= apcs_pkg::ACC_W'(conv_mag))
						acc <= trial; // see RULE7
					sar_bit <= sar_bit - 1'b1;
				end
				ENC_DONE: result <= {raw_sign, apcs_pkg::CHORD_CODE[seg],
					acc}; // see RULE6 see RULE13
				default: ;
			endcase
		end
	end

	// The word moves only while the transmit strobe is low, so the
	// bit clock side never samples it in mid-change.
	always_ff @(posedge mclk) begin
		if (srst)
			tx_word <= apcs_pkg::IDLE_WORD;
		else if (tx_fall)
			tx_word <= result; // see RULE2
	end

	// The receive register is still once its strobe is low.
	always_ff @(posedge mclk) begin
		if (srst) begin
			dec_valid <= 1'b0;
			dec_sign <= apcs_pkg::SIGN_POSITIVE;
			dec_mag <= '0;
		end else begin
			dec_valid <= rx_fall; // see RULE12 see RULE3
			if (rx_fall) begin
				dec_sign <= rx_sh[apcs_pkg::SIGN_POS];
				dec_mag <= apcs_pkg::MAG_W'(
					apcs_pkg::ACC_W'(apcs_pkg::SEG_STEP[dec_seg]) *
					apcs_pkg::ACC_W'(rx_sh[apcs_pkg::STEP_HI:0]) +
					apcs_pkg::ACC_W'(apcs_pkg::SEG_BASE[dec_seg])); // see RULE7
			end
		end
	end

	always_ff @(posedge link.transmit_bit_clock) begin
		tx_rst_meta <= srst;
		tx_rst <= tx_rst_meta;
	end

	// Release needs one more bit clock edge after the strobe falls.
	always_ff @(posedge link.transmit_bit_clock) begin
		if (tx_rst) begin
			tx_cnt <= 4'h0;
			tx_sh <= apcs_pkg::IDLE_WORD;
			link.tx_serial_out <= 1'b1;
			link.tx_serial_oe <= 1'b0;
		end else if (link.transmit_frame_strobe) begin
			link.tx_serial_oe <= 1'b1; // see RULE11
			if (tx_cnt == 4'h0) begin
				link.tx_serial_out <= tx_word[apcs_pkg::SIGN_POS];
				tx_sh <= tx_word << 1; // see RULE13
				tx_cnt <= 4'h1;
			end else begin
				link.tx_serial_out <= tx_sh[apcs_pkg::SIGN_POS];
				tx_sh <= tx_sh << 1;
				if (tx_cnt != apcs_pkg::BITS_PER_WORD)
					tx_cnt <= tx_cnt + 1'b1;
			end
		end else begin
			tx_cnt <= 4'h0;
			link.tx_serial_oe <= 1'b0; // see RULE11
		end
	end

	always_ff @(posedge link.receive_bit_clock) begin
		rx_rst_meta <= srst;
		rx_rst <= rx_rst_meta;
	end

	// Bits beyond the eighth are dropped if the strobe stays high.
	always_ff @(posedge link.receive_bit_clock) begin
		if (rx_rst) begin
			rx_cnt <= 4'h0;
			rx_sh <= apcs_pkg::IDLE_WORD;
		end else if (link.receive_frame_strobe) begin
			if (rx_cnt != apcs_pkg::BITS_PER_WORD) begin
				rx_sh <= {rx_sh[apcs_pkg::WORD_W-2:0],
					link.rx_serial_data}; // see RULE10 see RULE13
				rx_cnt <= rx_cnt + 1'b1;
			end
		end else begin
			rx_cnt <= 4'h0;
		end
	end
endmodule: apcs_codec_dev

// *** rtl/apcs_mux_end.sv ***
`timescale 1ns/100ps
module apcs_mux_end #(
	parameter int FRAME_CYCLES = apcs_pkg::FRAME_CYCLES
) (
	input wire logic mclk,
	input wire logic srst,
	apcs_link_if.mux link,
	input wire logic send_valid,
	output logic send_ready,
	input wire logic [apcs_pkg::WORD_W-1:0] send_word,
	output logic got_valid,
	output logic [apcs_pkg::WORD_W-1:0] got_word
);
	localparam int HALF = apcs_pkg::BCLK_HALF_CYCLES;
	localparam int BIT_CYCLES = 2 * HALF;
	logic [15:0] frame_cnt;
	logic [7:0] ph;
	logic [3:0] nbit;
	logic strobe;
	logic start;
	logic held;
	logic next_held;
	logic [apcs_pkg::WORD_W-1:0] hold;
	logic [apcs_pkg::WORD_W-1:0] out_sh;
	logic [apcs_pkg::WORD_W-1:0] cap_sh;
	logic [2:0] line_sync;
	logic line_lvl;
	logic accept;

	assign start = frame_cnt == 16'h0;
	assign accept = send_valid && send_ready;

	always_ff @(posedge mclk) begin
		if (srst) begin
			// The first frame waits two bit clocks, so the device side
			// clears itself on edges with its strobes still low.
			frame_cnt <= 16'(FRAME_CYCLES - 2 * BIT_CYCLES);
			ph <= 8'h0;
		end else begin
			frame_cnt <= (frame_cnt == 16'(FRAME_CYCLES - 1)) ?
				16'h0 : frame_cnt + 1'b1; // see RULE9
			ph <= (ph == 8'(2 * HALF - 1)) ? 8'h0 : ph + 1'b1;
		end
	end

	// One divided clock serves both directions; it runs free.
	always_ff @(posedge mclk) begin
		if (srst) begin
			link.transmit_bit_clock <= 1'b0;
			link.receive_bit_clock <= 1'b0;
		end else if (ph == 8'h0 || ph == 8'(HALF)) begin
			link.transmit_bit_clock <= ph != 8'h0;
			link.receive_bit_clock <= ph != 8'h0;
		end
	end

	// Strobes change on falling bit clock edges and end after eight
	// rising edges, leaving the rest of the frame low.
	always_ff @(posedge mclk) begin
		if (srst) begin
			strobe <= 1'b0;
			nbit <= 4'h0;
			link.transmit_frame_strobe <= 1'b0;
			link.receive_frame_strobe <= 1'b0;
		end else begin
			if (start) begin
				strobe <= 1'b1;
				nbit <= 4'h0;
			end else if (ph == 8'h0 && nbit == apcs_pkg::BITS_PER_WORD) begin
				strobe <= 1'b0; // see RULE1 see RULE12 see RULE3 see RULE2
			end else if (ph == 8'(HALF) && strobe) begin
				nbit <= nbit + 1'b1; // see RULE8
			end
			link.transmit_frame_strobe <= start ? 1'b1 :
				(ph == 8'h0 && nbit == apcs_pkg::BITS_PER_WORD) ? 1'b0 :
				link.transmit_frame_strobe;
			link.receive_frame_strobe <= start ? 1'b1 :
				(ph == 8'h0 && nbit == apcs_pkg::BITS_PER_WORD) ? 1'b0 :
				link.receive_frame_strobe;
		end
	end

	always_comb begin
		next_held = held;
		if (accept)
			next_held = 1'b1;
		else if (start)
			next_held = 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			held <= 1'b0;
			send_ready <= 1'b0;
			hold <= apcs_pkg::IDLE_WORD;
		end else begin
			held <= next_held;
			send_ready <= !next_held;
			if (accept)
				hold <= send_word;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			out_sh <= apcs_pkg::IDLE_WORD;
			link.rx_serial_data <= 1'b0;
		end else if (start) begin
			link.rx_serial_data <= held ? hold[apcs_pkg::SIGN_POS] :
				apcs_pkg::IDLE_WORD[apcs_pkg::SIGN_POS]; // see RULE13
			out_sh <= (held ? hold : apcs_pkg::IDLE_WORD) << 1;
		end else if (ph == 8'h0 && strobe &&
			nbit != apcs_pkg::BITS_PER_WORD) begin
			link.rx_serial_data <= out_sh[apcs_pkg::SIGN_POS];
			out_sh <= out_sh << 1;
		end
	end

	// The device line is sampled mid-bit, long after it settles.
	always_ff @(posedge mclk) begin
		if (srst) begin
			line_sync <= 3'h7;
			line_lvl <= 1'b1;
			cap_sh <= 8'h0;
			got_valid <= 1'b0;
			got_word <= 8'h0;
		end else begin
			line_sync <= {line_sync[1:0], link.tx_serial_line};
			if (line_sync[1] == line_sync[2])
				line_lvl <= line_sync[2];
			got_valid <= 1'b0;
			if (ph == 8'h0 && strobe && nbit != 4'h0) begin
				cap_sh <= {cap_sh[6:0], line_lvl};
				if (nbit == apcs_pkg::BITS_PER_WORD) begin
					got_valid <= 1'b1;
					got_word <= {cap_sh[6:0], line_lvl};
				end
			end
		end
	end
endmodule: apcs_mux_end

// *** verif/apcs_link_sva.sv ***
`timescale 1ns/100ps
module apcs_link_sva #(
	parameter int FRAME_CYCLES = 200
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic transmit_frame_strobe,
	input wire logic transmit_bit_clock,
	input wire logic receive_frame_strobe,
	input wire logic receive_bit_clock,
	input wire logic tx_serial_out,
	input wire logic tx_serial_oe,
	input wire logic tx_serial_line,
	input wire logic rx_serial_data
);
	localparam int HIGH_N = 16 * apcs_pkg::BCLK_HALF_CYCLES;
	wire tfs = transmit_frame_strobe;
	wire tbc = transmit_bit_clock;
	wire rfs = receive_frame_strobe;
	wire rbc = receive_bit_clock;
	logic [8:0] hi_cnt;
	logic [3:0] rx_edges;
	logic armed;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (srst);
	always_ff @(posedge mclk) begin
		if (srst || !tfs) begin
			hi_cnt <= 9'h000;
		end else begin
			hi_cnt <= hi_cnt + 9'h001;
		end
	end
	// The link end settles at its first bit clock edge, not at reset.
	always_ff @(posedge mclk) begin
		if (srst) begin
			armed <= 1'b0;
		end else if ($rose(tbc)) begin
			armed <= 1'b1;
		end
	end
	always_ff @(posedge mclk) begin
		if (srst || !rfs) begin
			rx_edges <= 4'h0;
		end else if ($rose(rbc)) begin
			rx_edges <= rx_edges + 4'h1;
		end
	end
	sequence low8;
		!rfs [*8];
	endsequence
	strobe_len_a:
		assert property ($fell(tfs) |-> hi_cnt == HIGH_N)
		else $error("transmit strobe width wrong");
	strobe_drop_a:
		assert property (tfs |-> hi_cnt < HIGH_N)
		else $error("transmit strobe held high too long");
	tx_gap_a:
		assert property ($fell(tfs) |-> !tfs ##1 !tfs)
		else $error("transmit strobe gap too short");
	rx_gap_a:
		assert property ($fell(rfs) |-> low8 ##1 low8 ##1 !rfs)
		else $error("receive strobe gap too short");
	frame_period_a:
		assert property ($rose(tfs) |-> ##FRAME_CYCLES $rose(tfs))
		else $error("frame period wrong");
	oe_drive_a:
		assert property (armed && $rose(tbc) && tfs |-> tx_serial_oe)
		else $error("output not driven in frame");
	oe_release_a:
		assert property (armed && $rose(tbc) && !tfs |-> !tx_serial_oe)
		else $error("output not released after frame");
	tx_edge_a:
		assert property (armed && tx_serial_oe && $changed(tx_serial_out)
			|-> $rose(tbc))
		else $error("output bit moved off a rising edge");
	rx_data_a:
		assert property (armed && rfs && $changed(rx_serial_data)
			|-> $fell(rbc) || $rose(rfs))
		else $error("receive bit moved while clock high");
	rx_count_a:
		assert property ($fell(rfs) |-> rx_edges == 4'h8)
		else $error("receive frame not eight bits");
endmodule: apcs_link_sva

// *** verif/tb.sv ***
`timescale 1ns/100ps
`define chk(nm, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("BAD %s expected %h seen %h", nm, e, g); \
	end \
end
module tb;
	typedef struct {
		logic sign;
		logic [apcs_pkg::MAG_W-1:0] mag;
		logic [apcs_pkg::WORD_W-1:0] word;
	} apcs_row_t;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic sample_valid = 1'b0;
	logic sample_sign = 1'b0;
	logic send_valid = 1'b0;
	logic [apcs_pkg::MAG_W-1:0] sample_mag = 22'h000000;
	logic [apcs_pkg::MAG_W-1:0] offset_level = 22'h000000;
	logic [apcs_pkg::WORD_W-1:0] send_word = 8'h00;
	logic sample_ready, dec_valid, dec_sign, send_ready, got_valid;
	logic [apcs_pkg::MAG_W-1:0] dec_mag;
	logic [apcs_pkg::WORD_W-1:0] got_word, wire_sh, rx_sh;
	int n_errors = 0;
	int comparisons = 0;
	int i;
	int acc;
	apcs_row_t rows [8] = '{
		'{1'b1, 22'h0004c5, 8'hd1}, '{1'b0, 22'h00960f, 8'h4f},
		'{1'b1, 22'h009d6c, 8'hf0}, '{1'b1, 22'h01c048, 8'he7},
		'{1'b0, 22'h03a69c, 8'h18}, '{1'b1, 22'h05f5be, 8'h83},
		'{1'b0, 22'h110058, 8'h3c}, '{1'b1, 22'h258b54, 8'haf}};
	always #12.5 mclk = ~mclk;
	apcs_link_if apcs_link_if_i ();
	apcs_codec_dev apcs_codec_dev_i (.mclk(mclk), .srst(srst),
		.link(apcs_link_if_i), .sample_valid(sample_valid),
		.sample_ready(sample_ready), .sample_sign(sample_sign),
		.sample_mag(sample_mag), .offset_level(offset_level),
		.dec_valid(dec_valid), .dec_sign(dec_sign), .dec_mag(dec_mag));
	apcs_mux_end #(.FRAME_CYCLES(200)) apcs_mux_end_i (.mclk(mclk),
		.srst(srst), .link(apcs_link_if_i), .send_valid(send_valid),
		.send_ready(send_ready), .send_word(send_word),
		.got_valid(got_valid), .got_word(got_word));
	apcs_link_sva #(.FRAME_CYCLES(200)) apcs_link_sva_i (.mclk(mclk),
		.srst(srst),
		.transmit_frame_strobe(apcs_link_if_i.transmit_frame_strobe),
		.transmit_bit_clock(apcs_link_if_i.transmit_bit_clock),
		.receive_frame_strobe(apcs_link_if_i.receive_frame_strobe),
		.receive_bit_clock(apcs_link_if_i.receive_bit_clock),
		.tx_serial_out(apcs_link_if_i.tx_serial_out),
		.tx_serial_oe(apcs_link_if_i.tx_serial_oe),
		.tx_serial_line(apcs_link_if_i.tx_serial_line),
		.rx_serial_data(apcs_link_if_i.rx_serial_data));
	// The wire is read where the far end reads it, not where it is driven.
	always @(negedge apcs_link_if_i.transmit_bit_clock) begin
		if (apcs_link_if_i.tx_serial_oe === 1'b1) begin
			wire_sh <= {wire_sh[6:0], apcs_link_if_i.tx_serial_line};
		end
	end
	always @(posedge apcs_link_if_i.receive_bit_clock) begin
		if (apcs_link_if_i.receive_frame_strobe === 1'b1) begin
			rx_sh <= {rx_sh[6:0], apcs_link_if_i.rx_serial_data};
		end
	end
	task tick();
		@(posedge mclk);
		#1;
	endtask: tick
	task push(input logic s, input logic [apcs_pkg::MAG_W-1:0] m);
		int k;
		sample_sign = s;
		sample_mag = m;
		sample_valid = 1'b1;
		for (k = 0; k < 400; k++) begin
			if (sample_ready === 1'b1) break;
			tick();
		end
		tick();
		sample_valid = 1'b0;
	endtask: push
	task send(input logic [apcs_pkg::WORD_W-1:0] w);
		int k;
		send_word = w;
		send_valid = 1'b1;
		for (k = 0; k < 400; k++) begin
			if (send_ready === 1'b1) break;
			tick();
		end
		tick();
		send_valid = 1'b0;
	endtask: send
	task wait_got(input bit skip, input logic [7:0] w);
		int k;
		for (k = 0; k < 1000; k++) begin
			tick();
			if (got_valid === 1'b1 &&
				(!skip || got_word !== apcs_pkg::IDLE_WORD)) break;
		end
		`chk("got_valid", 1'b1, got_valid)
		`chk("tx_wire", w, wire_sh)
		`chk("got_word", w, got_word)
	endtask: wait_got
	task wait_dec(input apcs_row_t r);
		int k;
		for (k = 0; k < 1000; k++) begin
			tick();
			if (dec_valid === 1'b1 && dec_mag !== 22'h000000) break;
		end
		`chk("dec_valid", 1'b1, dec_valid)
		`chk("rx_wire", r.word, rx_sh)
		`chk("dec_sign", r.sign, dec_sign)
		`chk("dec_mag", r.mag, dec_mag)
	endtask: wait_dec
	task end_sim();
		$display("counts: %0d mismatches, %0d comparisons", n_errors,
			comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask: end_sim
	initial begin
		#1000000;
		n_errors++;
		$display("BAD watchdog expected done seen hang");
		end_sim();
	end
	initial begin
		repeat (12) tick();
		`chk("send_ready", 1'b0, send_ready)
		`chk("sample_ready", 1'b0, sample_ready)
		`chk("dec_valid", 1'b0, dec_valid)
		srst = 1'b0;
		tick();
		`chk("send_ready", 1'b1, send_ready)
		`chk("sample_ready", 1'b1, sample_ready)
		// The device output settles at the first bit clock edge.
		repeat (20) tick();
		`chk("oe", 1'b0, apcs_link_if_i.tx_serial_oe)
		$display("test reset done");
		for (i = 0; i < 8; i++) begin
			push(rows[i].sign, rows[i].mag);
			send(rows[i].word);
			wait_dec(rows[i]);
			wait_got(1'b1, rows[i].word);
		end
		$display("test rows done");
		offset_level = 22'h0004c5;
		push(1'b0, 22'h000100);
		wait_got(1'b1, 8'h50);
		push(1'b0, 22'h000000);
		wait_got(1'b1, 8'h50);
		push(1'b1, 22'h01c50f);
		wait_got(1'b1, 8'he7);
		offset_level = 22'h000000;
		$display("test offset done");
		// Filling starts right after a frame ends, so no word leaves early.
		wait_got(1'b0, apcs_pkg::IDLE_WORD);
		acc = 0;
		sample_mag = 22'h00960f;
		sample_sign = 1'b0;
		sample_valid = 1'b1;
		for (i = 0; i < 20; i++) begin
			if (sample_ready === 1'b1) acc++;
			tick();
		end
		sample_valid = 1'b0;
		`chk("accepted", apcs_pkg::FIFO_DEPTH, acc)
		`chk("sample_ready", 1'b0, sample_ready)
		wait_got(1'b1, 8'h4f);
		for (i = 1; i < 16; i++) begin
			wait_got(1'b0, 8'h4f);
		end
		wait_got(1'b0, apcs_pkg::IDLE_WORD);
		$display("test fill done");
		end_sim();
	end
endmodule: tb
